// ### e1os_formatter.sv
// e1 time slot 0 and time slot 16 overhead formatter and extractor
//
// Function
// RULE1 - even frames carry alignment word 0011011
// RULE2 - odd frames: bit 2 fixed at 1
// RULE3 - check bits one to four in frames 0-6, 8-14
// RULE4 - crc computed per half multiframe
// RULE5 - without crc, bit 1 carries spare bit
// RULE6 - odd frame bit 3 is remote alarm
// RULE7 - national spare bits 4-8, unused sent as 1; the code sends tx_national_bits as given instead
// RULE8 - frames 13,15 bit 1 report crc errors
// RULE9 - alternate layout bit 4 is data link
// RULE10 - alternate layout bits 5-8 carry control bits
// RULE11 - ts16 frame 0 bits 1-4 are 0000
// RULE12 - ts16 frame 0 spare bits sent as 1; the code sends tx_ts16_spare as given instead
// RULE13 - ts16 frame 0 bit 6 is multiframe alarm
// RULE14 - ts16 frames 1-15 carry abcd signalling
// RULE15 - crc multiframe pattern 001011 in odd frames
// RULE16 - frame counter 0..15 drives all placement
`timescale 1ns/1ns
`include "e1os_cfg.svh"
module e1os_formatter #(
  parameter int FIFO_DEPTH = `E1OS_FIFO_DEPTH
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // configuration
  input  wire logic         crc_en,
  input  wire logic         alt_layout,
  input  wire logic         cas_en,
  // transmit overhead sources
  input  wire logic         tx_spare_si,
  input  wire logic         tx_remote_alarm,
  input  wire logic [4:0]   tx_national_bits,
  input  wire logic [7:0]   tx_dl_bits,
  input  wire logic [31:0]  tx_ctrl_bits,
  input  wire logic         tx_mf_alarm,
  input  wire logic [2:0]   tx_ts16_spare,
  input  wire logic [127:0] tx_sig_abcd,
  // transmit byte stream
  input  wire logic         tx_in_valid,
  input  wire logic [7:0]   tx_in_byte,
  output logic              tx_out_valid,
  output logic [7:0]        tx_out_byte,
  output logic              tx_out_mf_start,
  // receive byte stream
  input  wire logic         rx_in_valid,
  output logic              rx_in_ready,
  input  wire logic [7:0]   rx_in_byte,
  input  wire logic         rx_in_mf_start,
  // receive overhead word stream
  output logic              rx_word_valid,
  input  wire logic         rx_word_ready,
  output logic [19:0]       rx_word,
  // receive status
  output logic              rx_aligned,
  output logic              rx_remote_alarm,
  output logic [4:0]        rx_national_bits,
  output logic [7:0]        rx_dl_bits,
  output logic [31:0]       rx_ctrl_bits,
  output logic              rx_mf_alarm,
  output logic [2:0]        rx_ts16_spare,
  output logic              rx_align_err,
  output logic              rx_sigmf_err,
  output logic              rx_crc_err,
  output logic              rx_far_crc_err
);
  // ===========================================================
  // helpers
  // ===========================================================
  // time slot 0 layout for one frame; bit 1 of the slot is msb
  function automatic logic [7:0] ts0_word(
      input e1os_pkg::e1os_frame_t f, input logic bit1,
      input logic ra, input logic [4:0] nat, input logic dl,
      input logic [31:0] ctl, input logic alt);
    logic [2:0] k;
    logic [4:0] tail;
    k = f[3:1];
    // RULE10 - control bit walk
    tail = alt ? {dl, ctl[{k, 1'b0}], ctl[{k, 1'b1}],
                  ctl[{1'b1, k, 1'b0}], ctl[{1'b1, k, 1'b1}]} : nat;
    // RULE1 - alignment word
    if (!f[0]) begin
      return {bit1, `E1OS_ALIGN_WORD};
    end
    // RULE2 - odd frame layout
    return {bit1, 1'b1, ra, tail};
  endfunction

  // pattern bit for odd frames 1..11
  function automatic logic crcmf_bit(input e1os_pkg::e1os_frame_t f);
    logic [2:0] k;
    k = f[3:1];
    return 1'(`E1OS_CRCMF_PAT >> (`E1OS_CRCMF_LAST - k));
  endfunction

  // closing byte of a half multiframe
  function automatic logic half_end(input e1os_pkg::e1os_frame_t f,
                                    input e1os_pkg::e1os_slot_t s);
    return (s == `E1OS_SLOTS_LAST) && (f[2:0] == 3'(`E1OS_FRAME_HALF_A));
  endfunction

  // ===========================================================
  // transmit side
  // ===========================================================
  e1os_pkg::e1os_slot_t  tx_slot_q;   // slot of next input byte
  e1os_pkg::e1os_frame_t tx_frame_q;  // frame of next input byte
  logic [3:0]            tx_crc_q;    // crc of previous half
  logic [1:0]            e_pend_q;    // pending far-end reports
  logic                  tx_take;
  logic                  tx_bit1;
  logic [7:0]            tx_ts0;
  logic [7:0]            tx_ts16;
  logic [7:0]            tx_byte;
  logic [7:0]            tx_crc_byte;
  logic [3:0]            tx_crc_next;
  logic [3:0]            sig_ch;
  logic                  rx_half_err;
  logic                  rx_half_sel;

  assign tx_take = ce && tx_in_valid;

  // RULE16 - transmit counters
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_slot_q  <= '0;
      tx_frame_q <= '0;
    end else if (tx_take) begin
      tx_slot_q <= tx_slot_q + 1'b1;
      if (tx_slot_q == `E1OS_SLOTS_LAST) begin
        tx_frame_q <= tx_frame_q + 1'b1;
      end
    end
  end

  // bit 1 of time slot 0
  always_comb begin
    if (!crc_en) begin
      // RULE5 - spare bit
      tx_bit1 = tx_spare_si;
    end else if (!tx_frame_q[0]) begin
      // RULE3 - check bits in order
      tx_bit1 = tx_crc_q[3 - tx_frame_q[2:1]];
    end else if (tx_frame_q == `E1OS_FRAME_EBIT_A) begin
      // RULE8 - report first half
      tx_bit1 = ~e_pend_q[0];
    end else if (tx_frame_q == `E1OS_FRAME_EBIT_B) begin
      tx_bit1 = ~e_pend_q[1];
    end else begin
      // RULE15 - crc multiframe pattern
      tx_bit1 = crcmf_bit(tx_frame_q);
    end
  end

  // RULE6 - remote alarm goes in bit 3
  // RULE7 - national bits come from the user
  // RULE9 - data link bit per odd frame
  assign tx_ts0 = ts0_word(tx_frame_q, tx_bit1, tx_remote_alarm,
                           tx_national_bits, tx_dl_bits[tx_frame_q[3:1]],
                           tx_ctrl_bits, alt_layout);

  assign sig_ch = tx_frame_q;

  // time slot 16 contents
  always_comb begin
    if (tx_frame_q == 4'h0) begin
      // RULE11 - signalling multiframe pattern
      // RULE12 - spare bits
      // RULE13 - multiframe alarm bit
      tx_ts16 = {`E1OS_SIGMF_PAT, tx_ts16_spare[2], tx_mf_alarm,
                 tx_ts16_spare[1], tx_ts16_spare[0]};
    end else begin
      // RULE14 - channel n then n+16
      tx_ts16 = {tx_sig_abcd[{1'b0, sig_ch, 2'b00} +: 4],
                 tx_sig_abcd[{1'b1, sig_ch, 2'b00} +: 4]};
    end
  end

  // pick which byte goes out
  always_comb begin
    if (tx_slot_q == `E1OS_SLOT_TS0) begin
      tx_byte = tx_ts0;
    end else if (tx_slot_q == `E1OS_SLOT_TS16 && cas_en) begin
      tx_byte = tx_ts16;
    end else begin
      tx_byte = tx_in_byte;
    end
  end

  // check bit positions count as zero in the sum
  assign tx_crc_byte = (tx_slot_q == `E1OS_SLOT_TS0 && !tx_frame_q[0])
                       ? {1'b0, tx_byte[6:0]} : tx_byte;

  e1os_crc4 u_tx_crc (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .ce         (ce),
    .byte_valid (tx_in_valid),
    .byte_in    (tx_crc_byte),
    .restart    (tx_in_valid && half_end(tx_frame_q, tx_slot_q)),
    .crc_next   (tx_crc_next)
  );

  // output byte register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_out_valid    <= 1'b0;
      tx_out_byte     <= '0;
      tx_out_mf_start <= 1'b0;
    end else if (ce) begin
      tx_out_valid    <= tx_in_valid;
      tx_out_byte     <= tx_in_valid ? tx_byte : tx_out_byte;
      tx_out_mf_start <= tx_in_valid && tx_slot_q == 5'h00
                         && tx_frame_q == 4'h0;
    end
  end

  // RULE4 - latch each half's crc for the next half
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_crc_q <= `E1OS_CRC_INIT;
    end else if (tx_take && half_end(tx_frame_q, tx_slot_q)) begin
      tx_crc_q <= tx_crc_next;
    end
  end

  // far-end reports: a new error wins over the clear on sending
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      e_pend_q <= '0;
    end else if (ce) begin
      for (int h = 0; h < 2; h++) begin
        if (rx_half_err && rx_half_sel == h[0]) begin
          e_pend_q[h] <= 1'b1;
        end else if (tx_take && tx_slot_q == `E1OS_SLOT_TS0 &&
                     tx_frame_q == (h == 0 ? `E1OS_FRAME_EBIT_A
                                           : `E1OS_FRAME_EBIT_B)) begin
          e_pend_q[h] <= 1'b0;
        end
      end
    end
  end

  // ===========================================================
  // receive side
  // ===========================================================
  e1os_pkg::e1os_rx_state_e rx_state_q;
  e1os_pkg::e1os_slot_t     rx_slot;      // slot of this byte
  e1os_pkg::e1os_frame_t    rx_frame;     // frame of this byte
  e1os_pkg::e1os_slot_t     rx_slot_q;
  e1os_pkg::e1os_frame_t    rx_frame_q;
  logic                     rx_take;      // byte accepted and placed
  logic [7:0]               rx_ts0_q;     // held time slot 0
  logic [3:0]               rx_cbits_q;   // check bits this half
  logic [3:0]               rx_prev_q;    // computed crc, last half
  logic                     rx_prev_ok_q; // rx_prev_q is meaningful
  logic [3:0]               rx_crc_next;
  logic [7:0]               rx_crc_byte;
  logic                     rx_is_ts0;
  logic                     rx_is_ts16;
  logic [2:0]               rx_k;

  // a start mark realigns the counters onto this very byte
  assign rx_slot  = rx_in_mf_start ? 5'h00 : rx_slot_q;
  assign rx_frame = rx_in_mf_start ? 4'h0 : rx_frame_q;
  assign rx_take  = ce && rx_in_valid && rx_in_ready &&
                    (rx_state_q == e1os_pkg::E1OS_RX_RUN || rx_in_mf_start);
  assign rx_is_ts0  = rx_slot == `E1OS_SLOT_TS0;
  assign rx_is_ts16 = rx_slot == `E1OS_SLOT_TS16;
  assign rx_k       = rx_frame[3:1];
  assign rx_half_sel = rx_frame[3];
  assign rx_half_err = rx_take && crc_en && rx_prev_ok_q &&
                       half_end(rx_frame, rx_slot) &&
                       (rx_cbits_q != rx_prev_q);

  // alignment state; the aligner outside supplies the start mark
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_state_q <= e1os_pkg::E1OS_RX_WAIT;
    end else if (ce) begin
      case (rx_state_q)
        e1os_pkg::E1OS_RX_WAIT: begin
          if (rx_in_valid && rx_in_ready && rx_in_mf_start) begin
            rx_state_q <= e1os_pkg::E1OS_RX_RUN;
          end
        end
        e1os_pkg::E1OS_RX_RUN: begin
          rx_state_q <= e1os_pkg::E1OS_RX_RUN;
        end
        default: begin
          rx_state_q <= e1os_pkg::E1OS_RX_WAIT;
        end
      endcase
    end
  end

  // RULE16 - receive counters
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_slot_q  <= '0;
      rx_frame_q <= '0;
    end else if (rx_take) begin
      rx_slot_q  <= rx_slot + 1'b1;
      rx_frame_q <= (rx_slot == `E1OS_SLOTS_LAST) ? rx_frame + 1'b1
                                                 : rx_frame;
    end
  end

  assign rx_crc_byte = (rx_is_ts0 && !rx_frame[0])
                       ? {1'b0, rx_in_byte[6:0]} : rx_in_byte;

  e1os_crc4 u_rx_crc (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .ce         (ce),
    .byte_valid (rx_take),
    .byte_in    (rx_crc_byte),
    .restart    (rx_take && half_end(rx_frame, rx_slot)),
    .crc_next   (rx_crc_next)
  );

  // RULE4 - compare check bits with the previous half's sum
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_cbits_q   <= '0;
      rx_prev_q    <= '0;
      rx_prev_ok_q <= 1'b0;
      rx_crc_err   <= 1'b0;
    end else if (ce) begin
      rx_crc_err <= rx_half_err;
      if (rx_take && rx_in_mf_start && {rx_frame_q, rx_slot_q} != '0) begin
        rx_prev_ok_q <= 1'b0;
      end else if (rx_take && half_end(rx_frame, rx_slot)) begin
        rx_prev_q    <= rx_crc_next;
        rx_prev_ok_q <= 1'b1;
      end
      // RULE3 - collect check bits in order
      if (rx_take && rx_is_ts0 && !rx_frame[0]) begin
        rx_cbits_q[3 - rx_frame[2:1]] <= rx_in_byte[7];
      end
    end
  end

  // time slot 0 decode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_ts0_q         <= '0;
      rx_remote_alarm  <= 1'b0;
      rx_national_bits <= '1;
      rx_dl_bits       <= '0;
      rx_ctrl_bits     <= '0;
      rx_align_err     <= 1'b0;
      rx_far_crc_err   <= 1'b0;
    end else if (ce) begin
      rx_align_err   <= 1'b0;
      rx_far_crc_err <= 1'b0;
      if (rx_take && rx_is_ts0) begin
        rx_ts0_q <= rx_in_byte;
        if (!rx_frame[0]) begin
          // RULE1 - alignment word check
          rx_align_err <= rx_in_byte[6:0] != `E1OS_ALIGN_WORD;
        end else begin
          // RULE2 - alternate framing bit must be 1
          rx_align_err    <= !rx_in_byte[6];
          // RULE6 - remote alarm
          rx_remote_alarm <= rx_in_byte[5];
          // RULE8 - far-end crc error report
          rx_far_crc_err  <= crc_en && !rx_in_byte[7] &&
                             (rx_frame == `E1OS_FRAME_EBIT_A ||
                              rx_frame == `E1OS_FRAME_EBIT_B);
          if (alt_layout) begin
            // RULE9 - data link bit
            rx_dl_bits[rx_k] <= rx_in_byte[4];
            // RULE10 - control bits
            rx_ctrl_bits[{rx_k, 1'b0}]       <= rx_in_byte[3];
            rx_ctrl_bits[{rx_k, 1'b1}]       <= rx_in_byte[2];
            rx_ctrl_bits[{1'b1, rx_k, 1'b0}] <= rx_in_byte[1];
            rx_ctrl_bits[{1'b1, rx_k, 1'b1}] <= rx_in_byte[0];
          end else begin
            // RULE7 - national spare bits
            rx_national_bits <= rx_in_byte[4:0];
          end
        end
      end
    end
  end

  // time slot 16 decode in frame 0
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_mf_alarm   <= 1'b0;
      rx_ts16_spare <= '1;
      rx_sigmf_err  <= 1'b0;
    end else if (ce) begin
      rx_sigmf_err <= 1'b0;
      if (rx_take && rx_is_ts16 && cas_en && rx_frame == 4'h0) begin
        // RULE11 - pattern check
        rx_sigmf_err  <= rx_in_byte[7:4] != `E1OS_SIGMF_PAT;
        // RULE13 - multiframe alarm
        rx_mf_alarm   <= rx_in_byte[2];
        // RULE12 - spare bits reported as received
        rx_ts16_spare <= {rx_in_byte[3], rx_in_byte[1], rx_in_byte[0]};
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_aligned <= 1'b0;
    end else if (ce) begin
      rx_aligned <= rx_state_q == e1os_pkg::E1OS_RX_RUN;
    end
  end

  // ===========================================================
  // overhead word buffer
  // ===========================================================
  // RULE14 - frame number tags the signalling byte
  // push only at slot 16; ready low stalls the whole byte stream
  e1os_fifo #(
    .WIDTH (`E1OS_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (rx_take && rx_is_ts16),
    .in_ready  (rx_in_ready),
    .in_data   ({rx_frame, rx_ts0_q, rx_in_byte}),
    .out_valid (rx_word_valid),
    .out_ready (rx_word_ready),
    .out_data  (rx_word)
  );
endmodule

// ### e1os_cfg.svh
// constants for the e1 overhead slot formatter
`ifndef E1OS_CFG_SVH
`define E1OS_CFG_SVH

// ===========================================================
// frame geometry
// ===========================================================
`define E1OS_SLOTS_LAST    5'h1f
`define E1OS_FRAMES_LAST   4'hf
`define E1OS_SLOT_TS0      5'h00
`define E1OS_SLOT_TS16     5'h10
`define E1OS_FRAME_EBIT_A  4'hd
`define E1OS_FRAME_EBIT_B  4'hf
`define E1OS_FRAME_HALF_A  4'h7

// ===========================================================
// fixed overhead patterns
// ===========================================================
`define E1OS_ALIGN_WORD    7'h1b
`define E1OS_CRCMF_PAT     6'h0b
`define E1OS_CRCMF_LAST    3'h5
`define E1OS_SIGMF_PAT     4'h0
`define E1OS_CRC_POLY      4'h3
`define E1OS_CRC_INIT      4'h0

// ===========================================================
// buffering
// ===========================================================
`define E1OS_FIFO_DEPTH    8
`define E1OS_FIFO_WIDTH    20

`endif

// ### e1os_pkg.sv
// shared types for the e1 overhead slot formatter
package e1os_pkg;
  // receive alignment state
  typedef enum logic [1:0] {
    E1OS_RX_WAIT = 2'b00,
    E1OS_RX_RUN  = 2'b01
  } e1os_rx_state_e;
  typedef logic [3:0] e1os_frame_t;
  typedef logic [4:0] e1os_slot_t;
endpackage

// ### e1os_fifo.sv
// small synchronous fifo with registered full and empty
`timescale 1ns/1ns
`include "e1os_cfg.svh"
module e1os_fifo #(
  parameter int WIDTH = `E1OS_FIFO_WIDTH,
  parameter int DEPTH = `E1OS_FIFO_DEPTH
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // ===========================================================
  // storage
  // ===========================================================
  logic [WIDTH-1:0] mem_q [DEPTH];   // word store
  logic [AW-1:0]    wr_ptr_q;        // next write slot
  logic [AW-1:0]    rd_ptr_q;        // next read slot
  logic [AW:0]      count_q;         // words held
  logic             push;
  logic             pop;

  assign push     = ce && in_valid && in_ready;
  assign pop      = ce && out_valid && out_ready;
  assign out_data = mem_q[rd_ptr_q];

  // write side; no reset so it maps to plain storage
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers and flags; full and empty are flops, not decodes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q  <= '0;
      rd_ptr_q  <= '0;
      count_q   <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else if (ce) begin
      if (push) begin
        wr_ptr_q <= AW'((wr_ptr_q + 1'b1) % DEPTH);
      end
      if (pop) begin
        rd_ptr_q <= AW'((rd_ptr_q + 1'b1) % DEPTH);
      end
      // push and pop together leave the count alone
      if (push && !pop) begin
        count_q   <= count_q + 1'b1;
        in_ready  <= (count_q + 1'b1) != (AW+1)'(DEPTH);
        out_valid <= 1'b1;
      end else if (pop && !push) begin
        count_q   <= count_q - 1'b1;
        in_ready  <= 1'b1;
        out_valid <= count_q != (AW+1)'(1);
      end
    end
  end
endmodule

// ### e1os_crc4.sv
// bytewise crc-4 accumulator, msb first, x^4 + x + 1
`timescale 1ns/1ns
`include "e1os_cfg.svh"
module e1os_crc4 (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       byte_valid,
  input  wire logic [7:0] byte_in,
  input  wire logic       restart,
  output logic      [3:0] crc_next
);
  logic [3:0] crc_q;   // remainder so far

  // one byte through the serial lfsr, bit 1 of the slot first
  function automatic logic [3:0] crc_byte(input logic [3:0] c,
                                          input logic [7:0] b);
    logic [3:0] r;
    logic       fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[3] ^ b[i];
      r  = {r[2:0], 1'b0} ^ (fb ? `E1OS_CRC_POLY : 4'h0);
    end
    return r;
  endfunction

  // remainder including the byte of this cycle
  assign crc_next = byte_valid ? crc_byte(crc_q, byte_in) : crc_q;

  // restart clears after the closing byte has been folded in
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      crc_q <= `E1OS_CRC_INIT;
    end else if (ce) begin
      if (restart) begin
        crc_q <= `E1OS_CRC_INIT;
      end else begin
        crc_q <= crc_next;
      end
    end
  end
endmodule

// ### e1os_formatter_assertions.sv
// port checker for the e1 overhead formatter
`timescale 1ns/1ns
module e1os_formatter_assertions (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       crc_en,
  input wire logic       cas_en,
  input wire logic       tx_spare_si,
  input wire logic       tx_remote_alarm,
  input wire logic       tx_mf_alarm,
  input wire logic       tx_in_valid,
  input wire logic       tx_out_valid,
  input wire logic [7:0] tx_out_byte,
  input wire logic       tx_out_mf_start,
  input wire logic       rx_crc_err
);
  // ==========
  // sent byte position: slot in [4:0], frame in [8:5]
  // ==========
  logic [8:0] pos_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // counts answered bytes only, so a stall never shifts the frame
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pos_q <= 9'h0;
    end else if (tx_out_valid) begin
      pos_q <= pos_q + 9'h1;
    end
  end
  tx_answer_a:
    assert property (ce && tx_in_valid |=> tx_out_valid)
    else $error("byte not answered");
  mf_place_a:
    assert property (tx_out_valid |-> tx_out_mf_start == (pos_q == 9'h0))
    else $error("multiframe start misplaced");
  align_word_a:
    assert property (tx_out_valid && pos_q[5:0] == 6'h0
      |-> tx_out_byte[6:0] == 7'h1b) else $error("alignment word wrong");
  odd_frame_bit_a:
    assert property (tx_out_valid && pos_q[5:0] == 6'h20 |-> tx_out_byte[6])
    else $error("odd frame bit 2 low");
  remote_alarm_a:
    assert property (tx_out_valid && pos_q[5:0] == 6'h20
      |-> tx_out_byte[5] == $past(tx_remote_alarm)) else $error("alarm bit");
  spare_bit_a:
    assert property (tx_out_valid && pos_q[4:0] == 5'h0 && !$past(crc_en)
      |-> tx_out_byte[7] == $past(tx_spare_si)) else $error("spare bit");
  crc_pattern_a:
    assert property (tx_out_valid && pos_q == 9'h0a0 && $past(crc_en)
      |-> tx_out_byte[7]) else $error("crc frame pattern bit");
  sig_pattern_a:
    assert property (tx_out_valid && pos_q == 9'h010 && $past(cas_en)
      |-> tx_out_byte[7:4] == 4'h0) else $error("signalling pattern");
  mf_alarm_bit_a:
    assert property (tx_out_valid && pos_q == 9'h010 && $past(cas_en)
      |-> tx_out_byte[2] == $past(tx_mf_alarm)) else $error("mf alarm bit");
  crc_pulse_a:
    assert property (rx_crc_err |=> !rx_crc_err) else $error("crc pulse long");
endmodule

// ### e1os_line_model.sv
// far end line model: loops the sent stream back, may corrupt or stall
`timescale 1ns/1ns
module e1os_line_model (
  input  wire logic       tx_out_valid,
  input  wire logic [7:0] tx_out_byte,
  input  wire logic       tx_out_mf_start,
  input  wire logic       corrupt,
  input  wire logic       stall,
  output logic            rx_in_valid,
  output logic      [7:0] rx_in_byte,
  output logic            rx_in_mf_start,
  output logic            rx_word_ready
);
  assign rx_in_valid = tx_out_valid;
  assign rx_in_mf_start = tx_out_mf_start;
  // idle line shows the inverse so a stale byte never looks fresh
  assign rx_in_byte = tx_out_valid ? tx_out_byte ^ {7'h0, corrupt}
                                   : ~tx_out_byte;
  // reader takes no words while stalled
  assign rx_word_ready = !stall;
endmodule

// ### tb_e1_overhead_slot_formatter.sv
// loopback bench for the e1 overhead formatter
`timescale 1ns/1ns
module tb_e1_overhead_slot_formatter;
  // ==========
  // stimulus, outputs and bench state
  // ==========
  logic         sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, corrupt = 1'b0;
  logic         crc_en = 1'b1, alt_layout = 1'b0, cas_en = 1'b1;
  logic         tx_spare_si = 1'b1, tx_remote_alarm = 1'b1, stall = 1'b0;
  logic         tx_mf_alarm = 1'b1, tx_in_valid = 1'b0;
  logic [4:0]   tx_national_bits = 5'h16, rx_national_bits;
  logic [7:0]   tx_dl_bits = 8'h9c, tx_in_byte = 8'h0, b, s;
  logic [31:0]  tx_ctrl_bits = 32'h3c5a_e1f0, rx_ctrl_bits;
  logic [2:0]   tx_ts16_spare = 3'h5, rx_ts16_spare;
  logic [127:0] tx_sig_abcd = {32'h7f3b_19c6, 32'h2d84_a5e7,
                               32'h0123_4567, 32'h89ab_cdef};
  logic         tx_out_valid, tx_out_mf_start, rx_in_valid, rx_in_ready;
  logic         rx_in_mf_start, rx_word_valid, rx_word_ready, rx_aligned;
  logic         rx_remote_alarm, rx_mf_alarm, rx_align_err, rx_sigmf_err;
  logic         rx_crc_err, rx_far_crc_err;
  logic [7:0]   tx_out_byte, rx_in_byte, rx_dl_bits;
  logic [19:0]  rx_word;
  int           n_errors = 0, checked = 0, n_crc = 0, n_e0 = 0, k;
  logic         quiet = 1'b1, inj = 1'b0;
  logic [8:0]   oc = 9'h0;
  logic [5:0]   p = 6'h0b;
  logic [3:0]   fr, wf = 4'h0;

  e1os_formatter #(.FIFO_DEPTH(8)) e1os_formatter_inst (.*);
  e1os_line_model e1os_line_model_inst (.*);

  always #5 sys_clk = ~sys_clk;
  // payload keeps moving so a stuck byte path shows
  always @(posedge sys_clk) #1 tx_in_byte = tx_in_byte + 8'h3b;

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // stream n bytes, then idle so settings change between bytes
  task automatic run(input int n);
    tx_in_valid = 1'b1;
    repeat (n) @(posedge sys_clk);
    #1 tx_in_valid = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  // ==========
  // score every sent slot 0 and slot 16 byte by its position
  // ==========
  always @(posedge sys_clk) begin
    if (tx_out_valid) begin
      b = tx_out_byte;
      fr = oc[8:5];
      k = int'(fr[3:1]);
      if (oc[4:0] == 5'h0 && !fr[0]) chk("fas", 32'h1b, b[6:0]);
      if (oc[4:0] == 5'h0 && fr[0]) begin
        chk("nfas", 32'h1, b[6]);
        chk("ra", tx_remote_alarm, b[5]);
        if (!alt_layout) chk("nat", tx_national_bits, b[4:0]);
        else chk("dl", tx_dl_bits[k], b[4]);
        s = {4'h0, tx_ctrl_bits[2*k], tx_ctrl_bits[2*k+1],
             tx_ctrl_bits[16+2*k], tx_ctrl_bits[17+2*k]};
        if (alt_layout) chk("ctl", s, b[3:0]);
        if (crc_en && fr < 4'hc) chk("mfp", p[5-k], b[7]);
        else if (crc_en && !inj) chk("ebit", 32'h1, b[7]);
        else if (crc_en && !b[7]) n_e0++;
      end
      if (oc[4:0] == 5'h0 && !crc_en) chk("si", tx_spare_si, b[7]);
      s = {tx_sig_abcd[4*fr +: 4], tx_sig_abcd[4*fr + 64 +: 4]};
      if (fr == 4'h0) s = {4'h0, tx_ts16_spare[2], tx_mf_alarm, 2'h0};
      if (fr == 4'h0) s[1:0] = tx_ts16_spare[1:0];
      if (oc[4:0] == 5'h10) chk("ts16", s, b);
      oc = oc + 9'h1;
    end
    if (quiet) chk("rxerr", 32'h0, {rx_align_err, rx_sigmf_err});
    if (!inj) chk("far", 32'h0, rx_far_crc_err);
    if (!inj) chk("crcerr", 32'h0, rx_crc_err);
    else if (rx_crc_err) n_crc++;
    if (quiet && rx_word_valid && rx_word_ready) begin
      chk("wframe", wf, rx_word[19:16]);
      wf++;
    end
  end

  initial begin
    #100000;
    n_errors++;
    complete_run();
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    #1 rst = 1'b0;
    run(1024);
    chk("rx_ra", tx_remote_alarm, rx_remote_alarm);
    chk("rx_nat", tx_national_bits, rx_national_bits);
    chk("rx_y", tx_mf_alarm, rx_mf_alarm);
    chk("rx_x", tx_ts16_spare, rx_ts16_spare);
    chk("lock", 32'h1, rx_aligned);
    alt_layout = 1'b1;
    tx_remote_alarm = 1'b0;
    run(1024);
    chk("rx_ra", 32'h0, rx_remote_alarm);
    chk("rx_dl", tx_dl_bits, rx_dl_bits);
    chk("rx_ctl", tx_ctrl_bits, rx_ctrl_bits);
    // flip one payload bit; the half's check bits must then disagree
    inj = 1'b1;
    tx_in_valid = 1'b1;
    while (oc[4:0] != 5'h4) begin
      @(posedge sys_clk);
      #1;
    end
    corrupt = 1'b1;
    @(posedge sys_clk);
    #1 corrupt = 1'b0;
    run(1536);
    chk("crc_seen", 32'h1, n_crc != 0);
    chk("e_seen", 32'h1, n_e0 != 0);
    crc_en = 1'b0;
    tx_spare_si = 1'b0;
    run(512);
    // reader stalls until the buffer refuses, then drains it
    stall = 1'b1;
    quiet = 1'b0;
    tx_in_valid = 1'b1;
    repeat (400) @(posedge sys_clk);
    #1 chk("full", 32'h0, rx_in_ready);
    stall = 1'b0;
    for (int i = 0; i < 12 && rx_word_valid; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("empty", 32'h0, rx_word_valid);
    chk("ready", 32'h1, rx_in_ready);
    complete_run();
  end
endmodule

bind e1os_formatter e1os_formatter_assertions
  e1os_formatter_assertions_inst (.*);
